//--- design/tsr_pkg.sv
// package of constants and types for the tdm serial routing setup block
// Function
// - line interface mode register resets to zero
// - clock route register resets to zero, unconnected
// - rx frame starts after rx sync delay
// - tx frame starts after tx sync delay
// - common bit clocks both directions from rx
// - common bit frames both directions from rx sync
// - division 10 gives 32 entries per direction
// - global mode holds enables and division
// - command 0xF0 selects shadow, 0x00 normal
// - routing ram occupies 0x700 to 0x7FF
// - 16-bit entries on 16-bit boundaries, two bytes apart
// - connect bit attaches channel, ignores clock selects
// - protocol field 1010 selects multichannel protocol
package tsr_pkg;

  // register offsets (byte addresses)
  localparam logic [11:0] OFS_LINE_MODE   = 12'h000;
  localparam logic [11:0] OFS_CLK_ROUTE   = 12'h004;
  localparam logic [11:0] OFS_GLOBAL_MODE = 12'h008;
  localparam logic [11:0] OFS_RAM_SELECT  = 12'h00C;
  localparam logic [11:0] OFS_GEN_LOW     = 12'h010;
  localparam logic [11:0] OFS_GEN_HIGH    = 12'h014;
  localparam logic [11:0] OFS_STATUS      = 12'h018;
  localparam logic [3:0]  RAM_BASE_NIBBLE = 4'h7;
  localparam int          RAM_ENTRIES     = 128;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;

  // line interface mode fields
  localparam int MODE_TX_DELAY_LSB = 0;
  localparam int MODE_COMMON_BIT   = 6;
  localparam int MODE_RX_DELAY_LSB = 12;

  // clock route fields (channel one, low byte)
  localparam int ROUTE_TX_CS_LSB  = 0;
  localparam int ROUTE_RX_CS_LSB  = 3;
  localparam int ROUTE_CONNECT    = 6;
  localparam int ROUTE_GRANT      = 7;

  // global mode and ram select fields
  localparam int GLB_DIVISION_LSB = 0;
  localparam int GLB_LINE_A_EN    = 2;
  localparam int GLB_LINE_B_EN    = 3;
  localparam int SEL_TX_A         = 4;
  localparam int SEL_RX_A         = 5;

  // general mode low fields
  localparam int          GEN_MODE_LSB = 0;
  localparam int          GEN_TX_EN    = 4;
  localparam int          GEN_RX_EN    = 5;
  localparam logic [3:0]  PROTO_MULTI  = 4'hA;

  // routing entry fields
  localparam int ENTRY_LAST       = 0;
  localparam int ENTRY_STROBE_LSB = 1;

  // bits per time slot, minus one
  localparam logic [2:0] SLOT_LAST_BIT = 3'h7;

  typedef enum logic [1:0] {TSR_IDLE, TSR_DELAY, TSR_RUN} tsr_phase_t;

  typedef struct packed {
    tsr_phase_t  phase;
    logic [1:0]  cnt;
    logic [2:0]  bits;
    logic [4:0]  ptr;
    logic        shadow;
    logic        start;
  } tsr_walk_t;

endpackage : tsr_pkg

//--- design/tsr_routing.sv
// routing configuration registers, routing ram and frame walkers of one tdm line
`timescale 1ns/1ns
module tsr_routing
  import tsr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        line_rx_clock_pin,
  input  wire logic        line_tx_clock_pin,
  input  wire logic        line_rx_sync_pin,
  input  wire logic        line_tx_sync_pin,
  output logic             rx_frame_start,
  output logic             tx_frame_start,
  output logic             rx_slot_active,
  output logic             tx_slot_active,
  output logic      [3:0]  slot_strobe_outputs,
  output logic             channel_tdm_connect,
  output logic      [2:0]  channel_rx_clock_select,
  output logic      [2:0]  channel_tx_clock_select,
  output logic             channel_rx_run,
  output logic             channel_tx_run,
  output logic             multichannel_protocol
);

  ////////////////////////////////////////////////////////////////////////////////
  // register state
  logic [31:0] line_interface_mode;
  logic [31:0] serial_clock_route;
  logic [7:0]  tdm_global_mode;
  logic [7:0]  routing_ram_select;
  logic [31:0] channel_general_mode_low;
  logic [31:0] channel_general_mode_high;
  logic [15:0] route_ram [RAM_ENTRIES];
  tsr_walk_t   rx_walk;
  tsr_walk_t   tx_walk;
  tsr_walk_t   next_rx_walk;
  tsr_walk_t   next_tx_walk;

  // table index of an entry: line a, direction, shadow half when divided
  function automatic logic [6:0] entry_index(input logic dir, input logic shadow,
                                             input logic [4:0] ptr, input logic [1:0] div);
    if (div[0])
      entry_index = {1'b0, dir, shadow, ptr[3:0]};
    else
      entry_index = {1'b0, dir, ptr}; // 32 entries per direction
  endfunction : entry_index

  // one serial clock step of a frame walker
  function automatic tsr_walk_t walk_step(input tsr_walk_t w, input logic edge_seen,
                                          input logic sync, input logic [1:0] delay,
                                          input logic shadow_req, input logic last,
                                          input logic enable);
    tsr_walk_t n;
    n = w;
    n.start = 1'b0;
    if (!enable)
    begin
      n.phase = TSR_IDLE;
    end
    else if (edge_seen)
    begin
      if (sync && w.phase != TSR_DELAY)
      begin
        n.cnt   = delay;
        n.phase = TSR_DELAY;
        if (delay == 2'h0)
        begin
          n.phase  = TSR_RUN;
          n.start  = 1'b1;
          n.bits   = 3'h0;
          n.ptr    = 5'h00;
          n.shadow = shadow_req;
        end
      end
      else
      begin
        case (w.phase)
          TSR_DELAY:
          begin
            if (w.cnt <= 2'h1)
            begin
              n.phase  = TSR_RUN; // frame begins after the set delay
              n.start  = 1'b1;
              n.bits   = 3'h0;
              n.ptr    = 5'h00;
              n.shadow = shadow_req; // ram area switches here and on a sync with zero delay
            end
            else
            begin
              n.cnt = w.cnt - 2'h1;
            end
          end
          TSR_RUN:
          begin
            n.bits = w.bits + 3'h1;
            if (w.bits == SLOT_LAST_BIT)
            begin
              if (last)
                n.phase = TSR_IDLE; // end of routing list, await next sync
              else
                n.ptr = w.ptr + 5'h01;
            end
          end
          default:
          begin
            n.phase = TSR_IDLE;
          end
        endcase
      end
    end
    walk_step = n;
  endfunction : walk_step

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge history
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [1:0] clk_prev;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      clk_prev <= 2'h0;
    end
    else
    begin
      pin_meta <= {line_tx_sync_pin, line_rx_sync_pin, line_tx_clock_pin, line_rx_clock_pin};
      pin_sync <= pin_meta;
      clk_prev <= pin_sync[1:0];
    end
  end

  // common mode takes clock and sync of both directions from the rx pins
  logic       common;
  logic       rx_edge;
  logic       tx_edge;
  logic       tx_sync_eff;
  logic [6:0] rx_idx;
  logic [6:0] tx_idx;
  logic [6:0] rx_next_idx;
  logic [15:0] rx_entry;
  logic [15:0] tx_entry;
  logic        line_on;

  assign common      = line_interface_mode[MODE_COMMON_BIT];
  assign rx_edge     = pin_sync[0] && !clk_prev[0];
  assign tx_edge     = common ? rx_edge : (pin_sync[1] && !clk_prev[1]);
  assign tx_sync_eff = common ? pin_sync[2] : pin_sync[3];
  assign line_on     = tdm_global_mode[GLB_LINE_A_EN];
  assign rx_idx      = entry_index(1'b0, rx_walk.shadow, rx_walk.ptr,
                                   tdm_global_mode[1:0]);
  assign tx_idx      = entry_index(1'b1, tx_walk.shadow, tx_walk.ptr,
                                   tdm_global_mode[1:0]);
  // entry the rx walker points at after this edge, so strobes track slot active
  assign rx_next_idx = entry_index(1'b0, next_rx_walk.shadow, next_rx_walk.ptr,
                                   tdm_global_mode[1:0]);
  assign rx_entry    = route_ram[rx_idx];
  assign tx_entry    = route_ram[tx_idx];

  // next walker states
  always_comb
  begin
    next_rx_walk = walk_step(rx_walk, rx_edge, pin_sync[2],
                             line_interface_mode[MODE_RX_DELAY_LSB +: 2],
                             routing_ram_select[SEL_RX_A], rx_entry[ENTRY_LAST], line_on);
    next_tx_walk = walk_step(tx_walk, tx_edge, tx_sync_eff,
                             line_interface_mode[MODE_TX_DELAY_LSB +: 2],
                             routing_ram_select[SEL_TX_A], tx_entry[ENTRY_LAST], line_on);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame walkers
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_walk <= '0;
      tx_walk <= '0;
    end
    else
    begin
      rx_walk <= next_rx_walk;
      tx_walk <= next_tx_walk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers, writes act on the next edge
  logic wr_hit_ram;
  assign wr_hit_ram = (addr[11:8] == RAM_BASE_NIBBLE);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      line_interface_mode       <= RST_WORD;
      serial_clock_route        <= RST_WORD;
      tdm_global_mode           <= RST_BYTE;
      routing_ram_select        <= RST_BYTE;
      channel_general_mode_low  <= RST_WORD;
      channel_general_mode_high <= RST_WORD;
    end
    else if (wr)
    begin
      case (addr)
        OFS_LINE_MODE:   line_interface_mode       <= wdata;
        OFS_CLK_ROUTE:   serial_clock_route        <= wdata;
        OFS_GLOBAL_MODE: tdm_global_mode           <= {4'h0, wdata[3:0]};
        OFS_RAM_SELECT:  routing_ram_select        <= {wdata[7:4], 4'h0};
        OFS_GEN_LOW:     channel_general_mode_low  <= wdata;
        OFS_GEN_HIGH:    channel_general_mode_high <= wdata;
        default:         ;
      endcase
    end
  end

  // routing ram: 16-bit entries, two bytes apart
  always_ff @(posedge clock)
  begin
    if (wr && wr_hit_ram)
      route_ram[addr[7:1]] <= wdata[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port, data valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      rdata <= RST_WORD;
    else if (rd && wr_hit_ram)
      rdata <= {16'h0000, route_ram[addr[7:1]]};
    else if (rd)
    begin
      case (addr)
        OFS_LINE_MODE:   rdata <= line_interface_mode;
        OFS_CLK_ROUTE:   rdata <= serial_clock_route;
        OFS_GLOBAL_MODE: rdata <= {24'h0, tdm_global_mode};
        OFS_RAM_SELECT:  rdata <= {24'h0, routing_ram_select};
        OFS_GEN_LOW:     rdata <= channel_general_mode_low;
        OFS_GEN_HIGH:    rdata <= channel_general_mode_high;
        OFS_STATUS:      rdata <= {8'h0, tx_walk.shadow, tx_walk.phase, tx_walk.ptr,
                                   8'h0, rx_walk.shadow, rx_walk.phase, rx_walk.ptr};
        default:         rdata <= RST_WORD; // unmapped reads as zero
      endcase
    end
    else
      rdata <= RST_WORD;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame and slot outputs
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_frame_start      <= 1'b0;
      tx_frame_start      <= 1'b0;
      rx_slot_active      <= 1'b0;
      tx_slot_active      <= 1'b0;
      slot_strobe_outputs <= 4'h0;
    end
    else
    begin
      rx_frame_start      <= next_rx_walk.start;
      tx_frame_start      <= next_tx_walk.start;
      rx_slot_active      <= (next_rx_walk.phase == TSR_RUN);
      tx_slot_active      <= (next_tx_walk.phase == TSR_RUN);
      slot_strobe_outputs <= (next_rx_walk.phase == TSR_RUN) ?
                             route_ram[rx_next_idx][ENTRY_STROBE_LSB +: 4] : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel attachment and protocol selection
  logic connect;
  logic multi;
  assign connect = serial_clock_route[ROUTE_CONNECT];
  assign multi   = (channel_general_mode_low[GEN_MODE_LSB +: 4] == PROTO_MULTI);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      channel_tdm_connect     <= 1'b0;
      channel_rx_clock_select <= 3'h0;
      channel_tx_clock_select <= 3'h0;
      channel_rx_run          <= 1'b0;
      channel_tx_run          <= 1'b0;
      multichannel_protocol   <= 1'b0;
    end
    else
    begin
      channel_tdm_connect     <= connect;
      channel_rx_clock_select <= connect ? 3'h0 :
                                 serial_clock_route[ROUTE_RX_CS_LSB +: 3];
      channel_tx_clock_select <= connect ? 3'h0 :
                                 serial_clock_route[ROUTE_TX_CS_LSB +: 3];
      channel_rx_run          <= connect && multi && channel_general_mode_low[GEN_RX_EN];
      channel_tx_run          <= connect && multi && channel_general_mode_low[GEN_TX_EN];
      multichannel_protocol   <= multi;
    end
  end

endmodule : tsr_routing

//--- tb/tsr_routing_monitor.sv
// assertion checker for the tdm serial routing setup block
`timescale 1ns/1ns
module tsr_routing_monitor
  import tsr_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        rx_frame_start,
  input wire logic        tx_frame_start,
  input wire logic        rx_slot_active,
  input wire logic [3:0]  slot_strobe_outputs,
  input wire logic        channel_tdm_connect,
  input wire logic [2:0]  channel_rx_clock_select,
  input wire logic [2:0]  channel_tx_clock_select,
  input wire logic        channel_rx_run,
  input wire logic        channel_tx_run,
  input wire logic        multichannel_protocol
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////////
  // register bus and channel outputs
  AST_RDATA_QUIET: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside read answer");
  AST_SELECT_MASK: assert property (channel_tdm_connect |->
    (channel_rx_clock_select == 3'h0) && (channel_tx_clock_select == 3'h0))
    else $error("clock selects not ignored while connected");
  AST_RX_RUN: assert property (channel_rx_run |-> channel_tdm_connect && multichannel_protocol)
    else $error("rx run without connect and protocol");
  AST_TX_RUN: assert property (channel_tx_run |-> channel_tdm_connect && multichannel_protocol)
    else $error("tx run without connect and protocol");
  AST_PROTO_WRITE: assert property (wr && (addr == OFS_GEN_LOW) && (wdata[3:0] == PROTO_MULTI)
    |-> ##[1:3] multichannel_protocol)
    else $error("protocol write did not select multichannel");

  ////////////////////////////////////////////////////////////////////////////////
  // frame walkers
  AST_RX_PULSE: assert property (rx_frame_start |=> !rx_frame_start)
    else $error("rx frame start longer than one cycle");
  AST_TX_PULSE: assert property (tx_frame_start |=> !tx_frame_start)
    else $error("tx frame start longer than one cycle");
  AST_START_RUNS: assert property (rx_frame_start |-> ##[0:2] rx_slot_active)
    else $error("rx frame start without active walker");
  AST_STROBE_QUIET: assert property (!rx_slot_active |-> slot_strobe_outputs == 4'h0)
    else $error("slot strobes while rx walker idle");
endmodule : tsr_routing_monitor

bind tsr_routing tsr_routing_monitor mon_u (.clock, .rst_b, .addr, .wdata, .wr, .rd, .rdata,
  .rx_frame_start, .tx_frame_start, .rx_slot_active, .slot_strobe_outputs,
  .channel_tdm_connect, .channel_rx_clock_select, .channel_tx_clock_select,
  .channel_rx_run, .channel_tx_run, .multichannel_protocol);

//--- tb/tsr_framer_model.sv
// behavioural model of the line framer that supplies serial clock and sync
`timescale 1ns/1ns
module tsr_framer_model (
  output logic line_rx_clock_pin,
  output logic line_tx_clock_pin,
  output logic line_rx_sync_pin,
  output logic line_tx_sync_pin
);
  time t_first;

  // clocks stand low between frames
  initial
  begin
    line_rx_clock_pin = 1'b0;
    line_tx_clock_pin = 1'b0;
    line_rx_sync_pin  = 1'b0;
    line_tx_sync_pin  = 1'b0;
    t_first           = 0;
  end

  // one frame: sync high across the first rising serial clock; tx pins mirror rx if both
  task automatic frame(input int n, input bit both);
    #37;
    for (int i = 0; i < n; i++)
    begin
      line_rx_sync_pin = (i == 0);
      line_tx_sync_pin = both && (i == 0);
      #400 line_rx_clock_pin = 1'b1;
      line_tx_clock_pin = both;
      if (i == 0)
        t_first = $time;
      #400 line_rx_clock_pin = 1'b0;
      line_tx_clock_pin = 1'b0;
    end
    line_rx_sync_pin = 1'b0;
    line_tx_sync_pin = 1'b0;
  endtask : frame
endmodule : tsr_framer_model

//--- tb/tsr_routing_test.sv
// self-checking bench for the tdm serial routing setup block
`timescale 1ns/1ns
module tsr_routing_test;
  import tsr_pkg::*;
  logic        clock, rst_b, wr, rd, rx_fs, tx_fs, rx_act, tx_act, conn, rx_run, tx_run, proto;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  strobe, first_strobe;
  logic [2:0]  rx_cs, tx_cs;
  wire logic   rck, tck, rsy, tsy;
  int          err_total, samples_checked, cycles, tx_starts;
  time         t_start, t_tx, lag;

  tsr_framer_model fr_u (.line_rx_clock_pin(rck), .line_tx_clock_pin(tck),
    .line_rx_sync_pin(rsy), .line_tx_sync_pin(tsy));
  tsr_routing dut_u (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .line_rx_clock_pin(rck), .line_tx_clock_pin(tck),
    .line_rx_sync_pin(rsy), .line_tx_sync_pin(tsy), .rx_frame_start(rx_fs),
    .tx_frame_start(tx_fs), .rx_slot_active(rx_act), .tx_slot_active(tx_act),
    .slot_strobe_outputs(strobe), .channel_tdm_connect(conn),
    .channel_rx_clock_select(rx_cs), .channel_tx_clock_select(tx_cs),
    .channel_rx_run(rx_run), .channel_tx_run(tx_run), .multichannel_protocol(proto));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, timeout and frame observers
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total = err_total + 1;
      results();
    end
    if (rx_fs === 1'b1)
      t_start <= $time;
    if (tx_fs === 1'b1)
    begin
      tx_starts <= tx_starts + 1;
      t_tx      <= $time;
    end
    if (strobe !== 4'h0 && first_strobe === 4'h0)
      first_strobe <= strobe;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare, bus and closing tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg

  task rchk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask : rchk

  task settle;
    repeat (3) @(posedge clock);
    #1;
  endtask : settle

  task results;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rd, wr, addr, wdata, rst_b, first_strobe, tx_starts, t_start, t_tx, cycles} = '0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    rchk(OFS_LINE_MODE, 32'h0);
    rchk(OFS_CLK_ROUTE, 32'h0);
    rchk(OFS_STATUS, 32'h0);
    $display("test reset_values done");
    wreg(OFS_GLOBAL_MODE, 32'hFF);
    rchk(OFS_GLOBAL_MODE, 32'h0F);
    wreg(OFS_RAM_SELECT, 32'hFF);
    rchk(OFS_RAM_SELECT, 32'hF0);
    wreg(OFS_RAM_SELECT, 32'h00);
    rchk(OFS_RAM_SELECT, 32'h00);
    wreg(OFS_GEN_HIGH, 32'h0780);
    rchk(OFS_GEN_HIGH, 32'h0780);
    wreg(12'h01C, 32'hFFFF_FFFF);
    wreg(OFS_STATUS, 32'hFFFF_FFFF);
    rchk(12'h01C, 32'h0);
    rchk(OFS_STATUS, 32'h0);
    wreg(OFS_CLK_ROUTE, 32'h3F);
    settle();
    check({25'h0, conn, rx_cs, tx_cs}, 32'h3F);
    wreg(OFS_CLK_ROUTE, 32'h7F);
    wreg(OFS_GEN_LOW, 32'h0A);
    settle();
    check({25'h0, conn, rx_cs, tx_cs}, 32'h40);
    check({29'h0, proto, rx_run, tx_run}, 32'h4);
    wreg(OFS_GEN_LOW, 32'h3A);
    settle();
    check({29'h0, proto, rx_run, tx_run}, 32'h7);
    $display("test registers done");
    wreg(12'h700, 32'h0A);
    wreg(12'h702, 32'h06);
    wreg(12'h704, 32'h03);
    wreg(12'h740, 32'h03);
    wreg(12'h7FE, 32'hABCD);
    rchk(12'h7FF, 32'hABCD);
    rchk(12'h702, 32'h06);
    $display("test routing_ram done");
    wreg(OFS_LINE_MODE, 32'h1041);
    rchk(OFS_LINE_MODE, 32'h1041);
    wreg(OFS_GLOBAL_MODE, 32'h06);
    fr_u.frame(28, 1'b0);
    settle();
    lag = t_start - fr_u.t_first;
    check({31'h0, (lag >= 800) && (lag <= 1400)}, 32'h1);
    check({28'h0, first_strobe}, 32'h5);
    check(32'(tx_starts), 32'h1);
    check(t_tx[31:0], t_start[31:0]);
    check({30'h0, rx_act, tx_act}, 32'h0);
    check({28'h0, strobe}, 32'h0);
    wreg(OFS_LINE_MODE, 32'h1001);
    fr_u.frame(28, 1'b1);
    settle();
    check({31'h0, t_start > fr_u.t_first}, 32'h1);
    check(32'(tx_starts), 32'h2);
    check(t_tx[31:0], t_start[31:0]);
    wreg(OFS_GLOBAL_MODE, 32'h0A);
    fr_u.frame(4, 1'b1);
    settle();
    check({31'h0, t_start < fr_u.t_first}, 32'h1);
    check(32'(tx_starts), 32'h2);
    wreg(12'h720, 32'h11);
    wreg(12'h760, 32'h03);
    wreg(OFS_LINE_MODE, 32'h1041);
    wreg(OFS_GLOBAL_MODE, 32'h05);
    wreg(OFS_RAM_SELECT, 32'hF0);
    first_strobe <= 4'h0;
    fr_u.frame(12, 1'b0);
    settle();
    check({28'h0, first_strobe}, 32'h8);
    check(32'(tx_starts), 32'h3);
    rchk(OFS_STATUS, 32'h0080_0080);
    $display("test frames done");
    results();
  end
endmodule : tsr_routing_test
